// ---- logic/acrr_pkg.sv ----
// Package for the converter control and result register block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one clock domain.
package acrr_pkg;

    // Register byte offsets, one aligned word each
    localparam int ACRR_ADDR_W = 5;
    localparam logic [ACRR_ADDR_W-1:0] ACRR_OFS_STATUS = 5'h00;
    localparam logic [ACRR_ADDR_W-1:0] ACRR_OFS_HIGH = 5'h04;
    localparam logic [ACRR_ADDR_W-1:0] ACRR_OFS_LOW = 5'h08;
    localparam logic [ACRR_ADDR_W-1:0] ACRR_OFS_CLOCK = 5'h0C;

    // Status/control field positions
    localparam int ACRR_DONE_BIT = 7;
    localparam int ACRR_IRQEN_BIT = 6;
    localparam int ACRR_CONT_BIT = 5;
    localparam int ACRR_CHAN_MSB = 4;

    // Clock/format field positions
    localparam int ACRR_PRESC_MSB = 7;
    localparam int ACRR_PRESC_LSB = 5;
    localparam int ACRR_ICLK_BIT = 4;
    localparam int ACRR_MODE_MSB = 3;
    localparam int ACRR_MODE_LSB = 2;

    // Channel codes
    localparam logic [4:0] ACRR_CH_LAST_PIN = 5'h07;
    localparam logic [4:0] ACRR_CH_REF_HIGH = 5'h1D;
    localparam logic [4:0] ACRR_CH_REF_LOW = 5'h1E;
    localparam logic [4:0] ACRR_CH_OFF = 5'h1F;

    // Justification codes
    localparam logic [1:0] ACRR_MODE_TRUNC = 2'h0;
    localparam logic [1:0] ACRR_MODE_RIGHT = 2'h1;
    localparam logic [1:0] ACRR_MODE_LEFT = 2'h2;
    localparam logic [1:0] ACRR_MODE_SIGNED = 2'h3;

    // Reset values
    localparam logic [7:0] ACRR_STATUS_RST = 8'h1F;
    localparam logic [7:0] ACRR_CLOCK_RST = 8'h04;

    // Divider terminal counts, one less than the ratio
    localparam logic [3:0] ACRR_DIV_LAST_1 = 4'h0;
    localparam logic [3:0] ACRR_DIV_LAST_2 = 4'h1;
    localparam logic [3:0] ACRR_DIV_LAST_4 = 4'h3;
    localparam logic [3:0] ACRR_DIV_LAST_8 = 4'h7;
    localparam logic [3:0] ACRR_DIV_LAST_16 = 4'hF;

    // Converter clock cycles per conversion, last index
    localparam logic [3:0] ACRR_CONV_LAST = 4'hF;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } acrr_result_t;

    typedef struct packed {
        logic [7:0] analog;
        logic ref_high;
        logic ref_low;
        logic power_down;
    } acrr_select_t;

    typedef enum logic {ACRR_IDLE, ACRR_CONVERT} acrr_state_t;

endpackage

// ---- logic/acrr_core.sv ----
// Control, clocking and result registers of an eight-channel 10-bit converter.
// Assumes the analog core presents its 10-bit result on conv_result_i, on core_clk_i,
// valid at the last converter tick; the oscillator clock arrives asynchronously.
`timescale 1ns/10ps
`default_nettype none
module acrr_core
    import acrr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [ACRR_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic crystal_osc_clock_i,
    input wire logic [9:0] conv_result_i,
    output logic conv_start_o,
    output logic conv_tick_o,
    output logic conv_active_o,
    output logic [7:0] analog_select_o,
    output logic high_ref_select_o,
    output logic low_ref_select_o,
    output logic conv_power_down_o,
    output logic done_irq_o
);

    function automatic logic [3:0] div_last(input logic [2:0] code);
        logic [3:0] last;
        last = ACRR_DIV_LAST_16;
        if (!code[2]) begin
            case (code[1:0])
                2'h0: last = ACRR_DIV_LAST_1;
                2'h1: last = ACRR_DIV_LAST_2;
                2'h2: last = ACRR_DIV_LAST_4;
                default: last = ACRR_DIV_LAST_8;
            endcase
        end
        return last;
    endfunction

    function automatic acrr_select_t decode_channel(input logic [4:0] code);
        acrr_select_t sel;
        sel = '0;
        if (code <= ACRR_CH_LAST_PIN) begin
            sel.analog[code[2:0]] = 1'b1;
        end else if (code == ACRR_CH_REF_HIGH) begin
            sel.ref_high = 1'b1;
        end else if (code == ACRR_CH_REF_LOW) begin
            sel.ref_low = 1'b1;
        end else if (code == ACRR_CH_OFF) begin
            sel.power_down = 1'b1;
        end
        // Unused codes select nothing, so their result is undefined
        return sel;
    endfunction

    function automatic acrr_result_t format_result(input logic [1:0] mode, input logic [9:0] res);
        acrr_result_t fmt;
        fmt = '0;
        case (mode)
            ACRR_MODE_TRUNC: fmt.low = res[9:2];
            ACRR_MODE_RIGHT: begin
                fmt.high = {6'h00, res[9:8]};
                fmt.low = res[7:0];
            end
            ACRR_MODE_LEFT: begin
                fmt.high = res[9:2];
                fmt.low = {res[1:0], 6'h00};
            end
            default: begin
                fmt.high = {~res[9], res[8:2]};
                fmt.low = {res[1:0], 6'h00};
            end
        endcase
        return fmt;
    endfunction

    logic avs_waitrequest_reg;
    logic [31:0] avs_readdata_reg;
    logic done_irq_enable;
    logic continuous_convert;
    logic [4:0] channel_select;
    logic [2:0] clock_prescaler;
    logic input_clock_select;
    logic [1:0] justify_sel;
    logic conversion_done_flag_reg;
    logic irq_pend_reg;
    logic lock_reg;
    logic [7:0] result_high_reg;
    logic [7:0] result_low_reg;
    logic osc_sync1_reg, osc_sync2_reg, osc_prev_reg;
    logic [3:0] div_cnt_reg;
    logic [3:0] tick_cnt_reg;
    acrr_state_t state_reg;
    logic active_reg;
    logic start_reg;
    logic conv_tick_reg;
    acrr_select_t select_reg;

    logic accept, wr_en, wr_status, wr_clock, rd_high, rd_low, rd_data;
    logic in_tick, adc_tick, conv_end, store_ok;
    logic [7:0] rd_mux;
    acrr_result_t fmt_now;

    // Bus slave: every access gets exactly one wait cycle, so side effects happen once
    assign accept = (avs_read_i | avs_write_i) & avs_waitrequest_reg;
    assign wr_en = accept & avs_write_i & avs_byteenable_i[0];
    assign wr_status = wr_en && (avs_address_i == ACRR_OFS_STATUS);
    assign wr_clock = wr_en && (avs_address_i == ACRR_OFS_CLOCK);
    assign rd_high = accept && avs_read_i && (avs_address_i == ACRR_OFS_HIGH);
    assign rd_low = accept && avs_read_i && (avs_address_i == ACRR_OFS_LOW);
    assign rd_data = rd_high | rd_low;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_reg <= 1'b1;
        end else begin
            avs_waitrequest_reg <= !accept;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        case (avs_address_i)
            ACRR_OFS_STATUS: rd_mux = {conversion_done_flag_reg & ~done_irq_enable,
                                       done_irq_enable, continuous_convert, channel_select};
            ACRR_OFS_HIGH: rd_mux = result_high_reg;
            ACRR_OFS_LOW: rd_mux = result_low_reg;
            ACRR_OFS_CLOCK: rd_mux = {clock_prescaler, input_clock_select, justify_sel, 2'h0};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_readdata_reg <= '0;
        end else if (accept && avs_read_i) begin
            avs_readdata_reg <= {24'h000000, rd_mux};
        end
    end

    // Status/control; the done flag position is ignored on write
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_irq_enable <= ACRR_STATUS_RST[ACRR_IRQEN_BIT];
            continuous_convert <= ACRR_STATUS_RST[ACRR_CONT_BIT];
            channel_select <= ACRR_STATUS_RST[ACRR_CHAN_MSB:0];
        end else if (wr_status) begin
            done_irq_enable <= avs_writedata_i[ACRR_IRQEN_BIT];
            continuous_convert <= avs_writedata_i[ACRR_CONT_BIT];
            channel_select <= avs_writedata_i[ACRR_CHAN_MSB:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clock_prescaler <= ACRR_CLOCK_RST[ACRR_PRESC_MSB:ACRR_PRESC_LSB];
            input_clock_select <= ACRR_CLOCK_RST[ACRR_ICLK_BIT];
            justify_sel <= ACRR_CLOCK_RST[ACRR_MODE_MSB:ACRR_MODE_LSB];
        end else if (wr_clock) begin
            clock_prescaler <= avs_writedata_i[ACRR_PRESC_MSB:ACRR_PRESC_LSB];
            input_clock_select <= avs_writedata_i[ACRR_ICLK_BIT];
            justify_sel <= avs_writedata_i[ACRR_MODE_MSB:ACRR_MODE_LSB];
        end
    end

    // Input mux drives straight from the written code
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            select_reg <= decode_channel(ACRR_STATUS_RST[ACRR_CHAN_MSB:0]);
        end else if (wr_status) begin
            select_reg <= decode_channel(avs_writedata_i[ACRR_CHAN_MSB:0]);
        end
    end

    // Oscillator is asynchronous; only its synchronised copy feeds edge detection
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_sync1_reg <= 1'b0;
            osc_sync2_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_sync1_reg <= crystal_osc_clock_i;
            osc_sync2_reg <= osc_sync1_reg;
            osc_prev_reg <= osc_sync2_reg;
        end
    end

    // Oscillator must run below half the bus clock or edges are missed
    assign in_tick = input_clock_select | (osc_sync2_reg & ~osc_prev_reg);
    assign adc_tick = in_tick && (div_cnt_reg == div_last(clock_prescaler));

    // Divider restarts with each conversion so sixteen ticks span sixteen periods
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt_reg <= '0;
        end else if (wr_status || adc_tick) begin
            div_cnt_reg <= '0;
        end else if (in_tick) begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    assign conv_end = (state_reg == ACRR_CONVERT) && adc_tick
                      && (tick_cnt_reg == ACRR_CONV_LAST) && !wr_status;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ACRR_IDLE;
            active_reg <= 1'b0;
            tick_cnt_reg <= '0;
        end else if (wr_status) begin
            // A write abandons any conversion in flight
            tick_cnt_reg <= '0;
            if (avs_writedata_i[ACRR_CHAN_MSB:0] == ACRR_CH_OFF) begin
                state_reg <= ACRR_IDLE;
                active_reg <= 1'b0;
            end else begin
                state_reg <= ACRR_CONVERT;
                active_reg <= 1'b1;
            end
        end else begin
            case (state_reg)
                ACRR_CONVERT: begin
                    if (conv_end) begin
                        tick_cnt_reg <= '0;
                        state_reg <= continuous_convert ? ACRR_CONVERT : ACRR_IDLE;
                        active_reg <= continuous_convert;
                    end else if (adc_tick) begin
                        tick_cnt_reg <= tick_cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= ACRR_IDLE;
                    active_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_reg <= 1'b0;
            conv_tick_reg <= 1'b0;
        end else begin
            start_reg <= wr_status && (avs_writedata_i[ACRR_CHAN_MSB:0] != ACRR_CH_OFF);
            conv_tick_reg <= adc_tick && (state_reg == ACRR_CONVERT);
        end
    end

    // Result registers; outside truncation mode a high read in the same cycle also blocks the store
    assign fmt_now = format_result(justify_sel, conv_result_i);
    assign store_ok = (justify_sel == ACRR_MODE_TRUNC) || (!lock_reg && !rd_high);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_high_reg <= '0;
            result_low_reg <= '0;
        end else if (conv_end && store_ok) begin
            result_high_reg <= fmt_now.high;
            result_low_reg <= fmt_now.low;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_reg <= 1'b0;
        end else if (justify_sel == ACRR_MODE_TRUNC) begin
            lock_reg <= 1'b0;
        end else if (rd_high) begin
            lock_reg <= 1'b1;
        end else if (rd_low) begin
            lock_reg <= 1'b0;
        end
    end

    // Set wins over a same-cycle data read
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conversion_done_flag_reg <= 1'b0;
        end else if (conv_end && !done_irq_enable) begin
            conversion_done_flag_reg <= 1'b1;
        end else if (rd_data || done_irq_enable) begin
            conversion_done_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_pend_reg <= 1'b0;
        end else if (conv_end && done_irq_enable) begin
            irq_pend_reg <= 1'b1;
        end else if (rd_data || wr_status) begin
            irq_pend_reg <= 1'b0;
        end
    end

    assign avs_waitrequest_o = avs_waitrequest_reg;
    assign avs_readdata_o = avs_readdata_reg;
    assign conv_start_o = start_reg;
    assign conv_tick_o = conv_tick_reg;
    assign conv_active_o = active_reg;
    assign analog_select_o = select_reg.analog;
    assign high_ref_select_o = select_reg.ref_high;
    assign low_ref_select_o = select_reg.ref_low;
    assign conv_power_down_o = select_reg.power_down;
    assign done_irq_o = irq_pend_reg;

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_status_write;
        wr_status && (avs_writedata_i[ACRR_CHAN_MSB:0] != ACRR_CH_OFF);
    endsequence
    sequence s_fresh_start;
        conv_start_o && conv_active_o && (tick_cnt_reg == '0);
    endsequence
    sequence s_bus_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    // Set wins, so a data read in the end cycle cannot keep the flag down
    done_flag_set_a: assert property (
        conv_end && !done_irq_enable |=> conversion_done_flag_reg)
        else $error("done flag not set at conversion end");
    done_flag_clear_a: assert property (
        conversion_done_flag_reg && rd_data && !conv_end |=> !conversion_done_flag_reg)
        else $error("done flag survived a data read");
    done_flag_zero_a: assert property (
        accept && avs_read_i && (avs_address_i == ACRR_OFS_STATUS) && done_irq_enable
        |=> !avs_readdata_o[ACRR_DONE_BIT])
        else $error("done flag read as one with interrupt enabled");
    irq_raise_a: assert property (
        conv_end && done_irq_enable |=> done_irq_o && !conversion_done_flag_reg)
        else $error("interrupt not raised at conversion end");
    irq_drop_a: assert property (
        done_irq_o && (rd_data || wr_status) && !conv_end |=> !done_irq_o)
        else $error("interrupt not dropped by read or write");
    mode_next_a: assert property (
        conv_end |=> (conv_active_o == $past(continuous_convert)))
        else $error("wrong continuation after conversion");
    power_off_a: assert property (
        wr_status && (avs_writedata_i[ACRR_CHAN_MSB:0] == ACRR_CH_OFF)
        |=> conv_power_down_o && !conv_active_o && (analog_select_o == '0))
        else $error("converter not powered off");
    ref_select_a: assert property (
        wr_status && (avs_writedata_i[ACRR_CHAN_MSB:0] == ACRR_CH_REF_HIGH)
        |=> high_ref_select_o && !low_ref_select_o && (analog_select_o == '0))
        else $error("high reference not selected");
    restart_conv_a: assert property (s_status_write |=> s_fresh_start)
        else $error("status write did not restart conversion");
    lock_freeze_a: assert property (
        lock_reg && !rd_low && (justify_sel != ACRR_MODE_TRUNC) |=> $stable(result_low_reg))
        else $error("low register changed while locked");
    left_layout_a: assert property (
        conv_end && store_ok && (justify_sel == ACRR_MODE_LEFT)
        |=> (result_high_reg == $past(conv_result_i[9:2])) && (result_low_reg[5:0] == '0))
        else $error("left layout wrong");
    trunc_layout_a: assert property (
        conv_end && (justify_sel == ACRR_MODE_TRUNC)
        |=> (result_high_reg == '0) && (result_low_reg == $past(conv_result_i[9:2])))
        else $error("truncation layout wrong");
    fast_length_a: assert property (
        s_status_write ##1 (input_clock_select && (clock_prescaler == 3'h0) && !wr_status) [*8]
        ##1 (input_clock_select && (clock_prescaler == 3'h0) && !wr_status) [*8] |-> conv_end)
        else $error("conversion not sixteen ticks long");
    bus_answer_a: assert property (accept |=> s_bus_answer)
        else $error("bus answer not one wait cycle");
endmodule
`default_nettype wire

// ---- sim/acrr_analog_model.sv ----
// Behavioural analog core: a fixed code for each selected input.
// Assumes the selects and active level come from the control block on the same clock.
`timescale 1ns/10ps
`default_nettype none
module acrr_analog_model
    import acrr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic conv_active_i,
    input wire logic [7:0] analog_select_i,
    input wire logic high_ref_select_i,
    input wire logic low_ref_select_i,
    input wire logic conv_power_down_i,
    output logic [9:0] conv_result_o
);
    logic [9:0] noise_reg;
    logic [9:0] level;
    // Toggles every cycle so a stale or idle sample never looks valid
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            noise_reg <= 10'h2A5;
        end else begin
            noise_reg <= ~noise_reg;
        end
    end
    always_comb begin
        level = noise_reg; // Unused codes select nothing
        for (int i = 0; i < 8; i++) begin
            if (analog_select_i[i]) begin
                level = 10'h155 + 10'(10'h041 * i);
            end
        end
        if (high_ref_select_i) begin
            level = 10'h3FF;
        end
        if (low_ref_select_i) begin
            level = 10'h000;
        end
    end
    assign conv_result_o = (conv_active_i && !conv_power_down_i) ? level : noise_reg;
endmodule
`default_nettype wire

// ---- sim/test_adc_control_result_regs.sv ----
// Self-checking bench for the converter control block and its result registers.
// Assumes the behavioural analog model, a 20 MHz bus clock and a 5 MHz oscillator.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module test_adc_control_result_regs
    import acrr_pkg::*;
;
    logic core_clk = 1'b0;
    logic osc_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ACRR_ADDR_W-1:0] addr = '0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] be_reg = 4'h1;
    logic [31:0] rdata;
    logic wait_req, active, pd, hi_ref, lo_ref, irq;
    logic [7:0] asel;
    logic [9:0] result;
    logic [7:0] q;
    logic [4:0] chans [4] = '{5'h00, 5'h07, 5'h1D, 5'h1E};
    int fail_count = 0;
    int n_tests = 0;
    logic start_p, tick_p;
    int ticks = 0;
    int starts = 0;

    acrr_core dut (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be_reg), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req), .crystal_osc_clock_i(osc_clk), .conv_result_i(result),
        .conv_start_o(start_p), .conv_tick_o(tick_p), .conv_active_o(active), .analog_select_o(asel),
        .high_ref_select_o(hi_ref), .low_ref_select_o(lo_ref), .conv_power_down_o(pd), .done_irq_o(irq)
    );
    acrr_analog_model analog (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .conv_active_i(active), .analog_select_i(asel),
        .high_ref_select_i(hi_ref), .low_ref_select_i(lo_ref), .conv_power_down_i(pd), .conv_result_o(result)
    );

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #37;
        forever #100 osc_clk = ~osc_clk;
    end
    // Counts converter ticks and start pulses for the length checks
    always @(posedge core_clk) begin
        ticks <= ticks + int'(tick_p === 1'b1);
        starts <= starts + int'(start_p === 1'b1);
    end

    task automatic results();
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is seen low, then lets one edge pass
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= {24'h000000, d};
        do begin
            @(posedge core_clk);
        end while (wait_req !== 1'b0);
        q = rdata[7:0];
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [4:0] a);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    // Waits are ended only by the watchdog, which counts a hang as a mismatch
    task automatic poll();
        do begin
            rd(ACRR_OFS_STATUS);
        end while (q[7] !== 1'b1);
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    function automatic logic [9:0] val(logic [4:0] ch);
        if (ch == ACRR_CH_REF_HIGH) return 10'h3FF;
        if (ch == ACRR_CH_REF_LOW) return 10'h000;
        return 10'h155 + 10'(10'h041 * ch);
    endfunction
    function automatic logic [15:0] lay(logic [1:0] m, logic [9:0] v);
        case (m)
            2'h0: return {8'h00, v[9:2]};
            2'h1: return {6'h00, v};
            2'h2: return {v[9:2], v[1:0], 6'h00};
            default: return {~v[9], v[8:2], v[1:0], 6'h00};
        endcase
    endfunction

    task automatic conv(input logic [4:0] ch, input logic [1:0] m);
        logic [7:0] h;
        wr(ACRR_OFS_STATUS, {3'h0, ch});
        poll();
        `CHK(q, {3'h4, ch})
        `CHK({asel, hi_ref, lo_ref}, {(ch < 5'h08) ? 8'h01 << ch[2:0] : 8'h00, ch == 5'h1D, ch == 5'h1E})
        rd(ACRR_OFS_HIGH);
        h = q;
        rd(ACRR_OFS_LOW);
        `CHK({h, q}, lay(m, val(ch)))
    endtask

    initial begin
        int n;
        int d;
        int t0;
        int s0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(ACRR_OFS_STATUS);
        `CHK({pd, q}, {1'b1, 8'h1F})
        rd(ACRR_OFS_CLOCK);
        `CHK(q, 8'h04)
        rd(5'h10);
        `CHK(q, 8'h00)
        wr(ACRR_OFS_CLOCK, 8'h14);
        // First result after power-off is thrown away while the core settles
        wr(ACRR_OFS_STATUS, 8'h00);
        poll();
        rd(ACRR_OFS_HIGH);
        rd(ACRR_OFS_LOW);
        for (int m = 0; m < 4; m++) begin
            wr(ACRR_OFS_CLOCK, {3'h0, 1'b1, 2'(m), 2'h0});
            rd(ACRR_OFS_CLOCK);
            `CHK(q, {3'h0, 1'b1, 2'(m), 2'h0})
            foreach (chans[k]) begin
                conv(chans[k], 2'(m));
            end
        end
        // Codes four and up give the slow clock software would pick here
        for (int p = 0; p < 8; p++) begin
            d = (p > 3) ? 16 : (1 << p);
            wr(ACRR_OFS_CLOCK, {3'(p), 1'b1, ACRR_MODE_RIGHT, 2'h0});
            t0 = ticks;
            s0 = starts;
            wr(ACRR_OFS_STATUS, 8'h45);
            wait_irq(n);
            `CHK(n >= 16 * d - 4 && n <= 17 * d + 4, 1'b1)
            rd(ACRR_OFS_STATUS);
            `CHK({irq, q}, 9'h145)
            `CHK(ticks - t0, 16)
            `CHK(starts - s0, 1)
            wr(ACRR_OFS_STATUS, 8'h45);
            `CHK(irq, 1'b0)
            wait_irq(n);
            rd(ACRR_OFS_HIGH);
            `CHK({irq, q}, 9'h002)
            rd(ACRR_OFS_LOW);
        end
        wr(ACRR_OFS_CLOCK, 8'h04);
        wr(ACRR_OFS_STATUS, 8'h45);
        wait_irq(n);
        `CHK(n >= 60 && n <= 76, 1'b1)
        rd(ACRR_OFS_HIGH);
        rd(ACRR_OFS_LOW);
        wr(ACRR_OFS_CLOCK, 8'h14);
        wr(ACRR_OFS_STATUS, 8'h23);
        for (int i = 0; i < 2; i++) begin
            poll();
            `CHK(q, 8'hA3)
            rd(ACRR_OFS_HIGH);
            rd(ACRR_OFS_LOW);
        end
        conv(5'h03, ACRR_MODE_RIGHT);
        repeat (60) @(posedge core_clk);
        rd(ACRR_OFS_STATUS);
        `CHK(q, 8'h03)
        wr(ACRR_OFS_STATUS, 8'h00);
        repeat (5) @(posedge core_clk);
        conv(5'h07, ACRR_MODE_RIGHT);
        rd(ACRR_OFS_STATUS);
        `CHK(q, 8'h07)
        wr(ACRR_OFS_STATUS, 8'h00);
        poll();
        rd(ACRR_OFS_HIGH);
        wr(ACRR_OFS_STATUS, 8'h07);
        repeat (60) @(posedge core_clk);
        rd(ACRR_OFS_LOW);
        `CHK(q, 8'h55)
        conv(5'h07, ACRR_MODE_RIGHT);
        wr(ACRR_OFS_CLOCK, 8'h10);
        wr(ACRR_OFS_STATUS, 8'h00);
        poll();
        rd(ACRR_OFS_HIGH);
        wr(ACRR_OFS_STATUS, 8'h07);
        poll();
        rd(ACRR_OFS_LOW);
        `CHK(q, 8'hC7)
        be_reg <= 4'h0;
        wr(ACRR_OFS_CLOCK, 8'hFF);
        be_reg <= 4'h1;
        rd(ACRR_OFS_CLOCK);
        `CHK(q, 8'h10)
        s0 = starts;
        wr(ACRR_OFS_STATUS, 8'h1F);
        repeat (40) @(posedge core_clk);
        rd(ACRR_OFS_STATUS);
        `CHK({pd, active, q}, {2'b10, 8'h1F})
        `CHK(starts - s0, 0)
        results();
    end

    // About five times the expected run length
    initial begin
        #1000000;
        fail_count++;
        $display("ERROR %0t: run timed out", $time);
        results();
    end
endmodule
`default_nettype wire
